// ---- spr_pkg.sv ----
// shared constants and types for the speed parameter register set and its controller
package spr_pkg;

    // ****************************************
    // command codes
    // ****************************************
    localparam logic [15:0] CMD_CMP_QCANCEL = 16'h0027;
    localparam logic [15:0] CMD_CMP_CLEAR = 16'h002D;
    localparam logic [15:0] CMD_WQ_BASE = 16'h00B0;
    localparam logic [15:0] CMD_RQ_BASE = 16'h00C0;
    localparam logic [15:0] CMD_WA_BASE = 16'h0090;
    localparam logic [15:0] CMD_RA_BASE = 16'h00D0;
    localparam logic [15:0] CMD_BASE_MASK = 16'hFFF0;
    localparam logic [15:0] CMD_START = 16'h0050;
    localparam logic [15:0] CMD_START_NEXT = 16'h0051;
    localparam logic [15:0] CMD_WCMP = 16'h0060;
    localparam logic [15:0] CMD_WCMP_QUEUE = 16'h0061;
    localparam logic [15:0] CMD_RCMP = 16'h0062;
    localparam logic [15:0] CMD_RSTATUS = 16'h0063;

    // ****************************************
    // parameter slots, widths, limits
    // ****************************************
    localparam logic [3:0] IDX_INIT = 4'h1;
    localparam logic [3:0] IDX_DEC = 4'h4;
    localparam logic [1:0] SLOT_INIT = 2'h0;
    localparam logic [1:0] SLOT_RUN = 2'h1;
    localparam logic [1:0] SLOT_ACC = 2'h2;
    localparam logic [1:0] SLOT_DEC = 2'h3;
    localparam int SPEED_W = 17;
    localparam int RATE_W = 16;
    localparam logic [16:0] SPEED_MAX = 17'h186A0;
    localparam logic [15:0] RATE_ZERO = 16'h0000;

    // ****************************************
    // queue status encodings
    // ****************************************
    localparam logic [1:0] PF_UNFIXED = 2'h0;
    localparam logic [1:0] PF_ONE = 2'h1;
    localparam logic [1:0] PF_FULL = 2'h2;

    // ****************************************
    // controller register map
    // ****************************************
    localparam logic [3:0] ADDR_CMD = 4'h0;
    localparam logic [3:0] ADDR_WDATA = 4'h4;
    localparam logic [3:0] ADDR_RDATA = 4'h8;
    localparam logic [3:0] ADDR_STATUS = 4'hC;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [0:0] {
        LINK_IDLE = 1'b0,
        LINK_WAIT = 1'b1
    } spr_link_st_type;

endpackage : spr_pkg

// ---- spr_link_if.sv ----
// command link between the controller and the speed parameter register set
`timescale 1ns/1ps
interface spr_link_if;
    logic cmd_valid;
    logic [15:0] cmd_code;
    logic [31:0] cmd_data;
    logic rsp_valid;
    logic [31:0] rsp_data;

    modport host (
        output cmd_valid,
        output cmd_code,
        output cmd_data,
        input rsp_valid,
        input rsp_data
    );

    modport dev (
        input cmd_valid,
        input cmd_code,
        input cmd_data,
        output rsp_valid,
        output rsp_data
    );
endinterface : spr_link_if

// ---- spr_regs.sv ----
// speed parameter register set with queued pre-registers and comparator three queue
// Operation
// - queue cancel drops comparator queue, keeps active
// - status clear unfixes comparator queue and active
// - initial speed holds start/stop speed, 1..100000
// - speeds 100000..131071 are taken as 100000
// - running speed is 17 bits, queued
// - controller sets running above initial speed; not checked here
// - active writes during a move override at once
// - acceleration rate is 16 bits, 1..65535
// - deceleration rate is 16 bits, 1..65535
// - deceleration rate used in automatic ramp-down too
// - zero deceleration rate falls back to acceleration
// - initial speed command codes
// - running speed command codes
// - acceleration rate command codes
// - deceleration rate command codes
// - queue write while stopped goes straight active
// - start fixes queue; completion shifts a full queue and restarts
`timescale 1ns/1ps
module spr_regs (
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    spr_link_if.dev link,
    input wire logic move_running_i,
    input wire logic move_done_i,
    input wire logic cmp_shift_i,
    output logic [16:0] initial_speed_o,
    output logic [16:0] running_speed_o,
    output logic [15:0] accel_rate_o,
    output logic [15:0] decel_rate_o,
    output logic [1:0] queue_status_o,
    output logic auto_start_o,
    output logic [31:0] comparator_three_value_o,
    output logic [1:0] comparator_queue_status_o,
    output logic comparator_fixed_o
);

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        logic [3:0][16:0] que;
        logic [3:0][16:0] act;
        logic [1:0] pfm;
        logic auto_start;
        logic [15:0] dec_eff;
        logic [31:0] cmp_q;
        logic [31:0] cmp_a;
        logic [1:0] pfc;
        logic cmp_fixed;
        logic refused;
        logic rsp_valid;
        logic [31:0] rsp_data;
    } spr_regs_state_type;

    spr_regs_state_type s;
    spr_regs_state_type next_s;

    // ****************************************
    // helpers
    // ****************************************
    // trims a written word to the slot width and clamps speeds
    function automatic logic [16:0] spr_fit(input logic [1:0] slot, input logic [31:0] d);
        logic [16:0] v;
        v = d[16:0];
        if (slot == spr_pkg::SLOT_INIT || slot == spr_pkg::SLOT_RUN)
        begin
            if (v > spr_pkg::SPEED_MAX)
            begin
                v = spr_pkg::SPEED_MAX;
            end
        end
        else
        begin
            v[16] = 1'b0;
        end
        return v;
    endfunction : spr_fit

    // tells whether a command belongs to one base group
    function automatic logic spr_in_group(input logic [15:0] code, input logic [15:0] base);
        return ((code & spr_pkg::CMD_BASE_MASK) == base)
            && (code[3:0] >= spr_pkg::IDX_INIT)
            && (code[3:0] <= spr_pkg::IDX_DEC);
    endfunction : spr_in_group

    logic [1:0] slot;
    logic [16:0] val;
    logic running;

    // ****************************************
    // next state
    // ****************************************
    // slot from command low nibble, value fitted to that slot
    always_comb
    begin
        slot = 2'(link.cmd_code[3:0] - spr_pkg::IDX_INIT);
        val = spr_fit(slot, link.cmd_data);
        running = move_running_i;
    end

    // command decode, queue shifting and comparator queue handling
    always_comb
    begin
        next_s = s;
        next_s.rsp_valid = 1'b0;
        next_s.rsp_data = 32'h00000000;
        next_s.auto_start = 1'b0;
        // end of a move: shift a full queue and restart, else unfix
        if (move_done_i)
        begin
            if (s.pfm == spr_pkg::PF_FULL)
            begin
                next_s.act = s.que;
                next_s.pfm = spr_pkg::PF_ONE;
                next_s.auto_start = 1'b1;
            end
            else
            begin
                next_s.pfm = spr_pkg::PF_UNFIXED;
            end
        end
        // comparator result went true-false: move the comparator queue on
        if (cmp_shift_i)
        begin
            if (s.pfc == spr_pkg::PF_FULL)
            begin
                next_s.cmp_a = s.cmp_q;
                next_s.pfc = spr_pkg::PF_ONE;
            end
            else if (s.pfc == spr_pkg::PF_ONE)
            begin
                next_s.pfc = spr_pkg::PF_UNFIXED;
                next_s.cmp_fixed = 1'b0;
            end
        end
        if (link.cmd_valid)
        begin
            next_s.rsp_valid = 1'b1;
            if (spr_in_group(link.cmd_code, spr_pkg::CMD_WQ_BASE))
            begin
                if (s.pfm == spr_pkg::PF_FULL)
                begin
                    next_s.refused = 1'b1; // full queue takes no data
                end
                else
                begin
                    next_s.que[slot] = val;
                    if (!running)
                    begin
                        next_s.act[slot] = val;
                    end
                end
            end
            else if (spr_in_group(link.cmd_code, spr_pkg::CMD_WA_BASE))
            begin
                next_s.act[slot] = val;
            end
            else if (spr_in_group(link.cmd_code, spr_pkg::CMD_RQ_BASE))
            begin
                next_s.rsp_data = {15'h0000, s.que[slot]};
            end
            else if (spr_in_group(link.cmd_code, spr_pkg::CMD_RA_BASE))
            begin
                next_s.rsp_data = {15'h0000, s.act[slot]};
            end
            else if (link.cmd_code == spr_pkg::CMD_START)
            begin
                if (!running)
                begin
                    next_s.pfm = spr_pkg::PF_ONE;
                end
                else if (s.pfm == spr_pkg::PF_ONE)
                begin
                    next_s.pfm = spr_pkg::PF_FULL;
                end
            end
            else if (link.cmd_code == spr_pkg::CMD_START_NEXT)
            begin
                if (running && s.pfm == spr_pkg::PF_ONE)
                begin
                    next_s.pfm = spr_pkg::PF_FULL;
                end
            end
            else if (link.cmd_code == spr_pkg::CMD_WCMP)
            begin
                next_s.cmp_a = link.cmd_data;
                next_s.cmp_fixed = 1'b1;
                if (s.pfc == spr_pkg::PF_UNFIXED)
                begin
                    next_s.pfc = spr_pkg::PF_ONE;
                end
            end
            else if (link.cmd_code == spr_pkg::CMD_WCMP_QUEUE)
            begin
                if (s.pfc == spr_pkg::PF_UNFIXED)
                begin
                    next_s.cmp_q = link.cmd_data;
                    next_s.cmp_a = link.cmd_data;
                    next_s.cmp_fixed = 1'b1;
                    next_s.pfc = spr_pkg::PF_ONE;
                end
                else if (s.pfc == spr_pkg::PF_ONE)
                begin
                    next_s.cmp_q = link.cmd_data;
                    next_s.pfc = spr_pkg::PF_FULL;
                end
                else
                begin
                    next_s.refused = 1'b1; // full comparator queue
                end
            end
            else if (link.cmd_code == spr_pkg::CMD_CMP_QCANCEL)
            begin
                next_s.cmp_q = 32'h00000000;
                next_s.pfc = spr_pkg::PF_UNFIXED;
            end
            else if (link.cmd_code == spr_pkg::CMD_CMP_CLEAR)
            begin
                next_s.pfc = spr_pkg::PF_UNFIXED;
                next_s.cmp_fixed = 1'b0;
            end
            else if (link.cmd_code == spr_pkg::CMD_RCMP)
            begin
                next_s.rsp_data = s.cmp_a;
            end
            else if (link.cmd_code == spr_pkg::CMD_RSTATUS)
            begin
                next_s.rsp_data = {26'h0000000, s.refused, s.cmp_fixed, s.pfc, s.pfm};
                next_s.refused = 1'b0; // read clears the refusal flag
            end
        end
        // a refusal in this cycle wins over the clearing read
        if (link.cmd_valid && s.pfm == spr_pkg::PF_FULL
            && spr_in_group(link.cmd_code, spr_pkg::CMD_WQ_BASE))
        begin
            next_s.refused = 1'b1;
        end
        if (link.cmd_valid && s.pfc == spr_pkg::PF_FULL
            && link.cmd_code == spr_pkg::CMD_WCMP_QUEUE)
        begin
            next_s.refused = 1'b1;
        end
        // effective deceleration rate, independent of ramp-down mode
        if (next_s.act[spr_pkg::SLOT_DEC][15:0] == spr_pkg::RATE_ZERO)
        begin
            next_s.dec_eff = next_s.act[spr_pkg::SLOT_ACC][15:0];
        end
        else
        begin
            next_s.dec_eff = next_s.act[spr_pkg::SLOT_DEC][15:0];
        end
    end

    // ****************************************
    // registers
    // ****************************************
    // all registers and queues clear to zero
    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            s <= '0;
        end
        else
        begin
            s <= next_s;
        end
    end

    // outputs taken straight from state
    assign initial_speed_o = s.act[spr_pkg::SLOT_INIT];
    assign running_speed_o = s.act[spr_pkg::SLOT_RUN]; // relied on, not checked
    assign accel_rate_o = s.act[spr_pkg::SLOT_ACC][15:0];
    assign decel_rate_o = s.dec_eff;
    assign queue_status_o = s.pfm;
    assign auto_start_o = s.auto_start;
    assign comparator_three_value_o = s.cmp_a;
    assign comparator_queue_status_o = s.pfc;
    assign comparator_fixed_o = s.cmp_fixed;
    assign link.rsp_valid = s.rsp_valid;
    assign link.rsp_data = s.rsp_data;

endmodule : spr_regs

// ---- spr_ctrl.sv ----
// controller end: axi4-lite register slave that issues commands on the link
`timescale 1ns/1ps
module spr_ctrl (
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    spr_link_if.host link,
    input wire logic [3:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [3:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i
);

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        logic awready;
        logic wready;
        logic [3:0] awaddr;
        logic [31:0] wbuf;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [31:0] wdata_reg;
        logic [31:0] rsp_reg;
        logic done;
        spr_pkg::spr_link_st_type st;
        logic cmd_valid;
        logic [15:0] cmd_code;
        logic [31:0] cmd_data;
    } spr_ctrl_state_type;

    spr_ctrl_state_type s;
    spr_ctrl_state_type next_s;

    // merges a bus word into a register under byte strobes
    function automatic logic [31:0] spr_merge(input logic [31:0] old, input logic [31:0] d,
                                              input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
        begin
            if (be[i])
            begin
                r[i*8 +: 8] = d[i*8 +: 8];
            end
        end
        return r;
    endfunction : spr_merge

    logic [31:0] cmd_word;

    // ****************************************
    // next state
    // ****************************************
    // bus channels, register writes, command launch and answer capture
    always_comb
    begin
        next_s = s;
        next_s.cmd_valid = 1'b0;
        cmd_word = spr_merge(32'h00000000, s.wbuf, s.wstrb);
        if (s_axi_awvalid_i && s.awready)
        begin
            next_s.awaddr = s_axi_awaddr_i;
            next_s.awready = 1'b0;
        end
        if (s_axi_wvalid_i && s.wready)
        begin
            next_s.wbuf = s_axi_wdata_i;
            next_s.wstrb = s_axi_wstrb_i;
            next_s.wready = 1'b0;
        end
        // both halves held: perform the write and answer
        if (!s.awready && !s.wready && !s.bvalid)
        begin
            next_s.bvalid = 1'b1;
            next_s.bresp = spr_pkg::RESP_OKAY;
            if (s.awaddr == spr_pkg::ADDR_WDATA)
            begin
                next_s.wdata_reg = spr_merge(s.wdata_reg, s.wbuf, s.wstrb);
            end
            else if (s.awaddr == spr_pkg::ADDR_CMD)
            begin
                if (s.st == spr_pkg::LINK_IDLE)
                begin
                    next_s.cmd_valid = 1'b1;
                    next_s.cmd_code = cmd_word[15:0];
                    next_s.cmd_data = s.wdata_reg;
                    next_s.st = spr_pkg::LINK_WAIT;
                    next_s.done = 1'b0;
                end
            end
            else if (s.awaddr != spr_pkg::ADDR_STATUS && s.awaddr != spr_pkg::ADDR_RDATA)
            begin
                next_s.bresp = spr_pkg::RESP_SLVERR;
            end
        end
        if (s.bvalid && s_axi_bready_i)
        begin
            next_s.bvalid = 1'b0;
            next_s.awready = 1'b1;
            next_s.wready = 1'b1;
        end
        // read channel
        if (s_axi_arvalid_i && s.arready)
        begin
            next_s.arready = 1'b0;
            next_s.rvalid = 1'b1;
            next_s.rresp = spr_pkg::RESP_OKAY;
            unique case (s_axi_araddr_i)
                spr_pkg::ADDR_CMD: next_s.rdata = {16'h0000, s.cmd_code};
                spr_pkg::ADDR_WDATA: next_s.rdata = s.wdata_reg;
                spr_pkg::ADDR_RDATA: next_s.rdata = s.rsp_reg;
                spr_pkg::ADDR_STATUS: next_s.rdata = {30'h00000000, s.done, s.st};
                default:
                begin
                    next_s.rdata = 32'h00000000;
                    next_s.rresp = spr_pkg::RESP_SLVERR;
                end
            endcase
        end
        if (s.rvalid && s_axi_rready_i)
        begin
            next_s.rvalid = 1'b0;
            next_s.arready = 1'b1;
        end
        // device answer ends the command
        if (s.st == spr_pkg::LINK_WAIT && link.rsp_valid)
        begin
            next_s.rsp_reg = link.rsp_data;
            next_s.st = spr_pkg::LINK_IDLE;
            next_s.done = 1'b1;
        end
    end

    // ****************************************
    // registers
    // ****************************************
    // ready flags come up after reset, all else clears
    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            s <= '0;
            s.awready <= 1'b1;
            s.wready <= 1'b1;
            s.arready <= 1'b1;
        end
        else
        begin
            s <= next_s;
        end
    end

    assign s_axi_awready_o = s.awready;
    assign s_axi_wready_o = s.wready;
    assign s_axi_bresp_o = s.bresp;
    assign s_axi_bvalid_o = s.bvalid;
    assign s_axi_arready_o = s.arready;
    assign s_axi_rdata_o = s.rdata;
    assign s_axi_rresp_o = s.rresp;
    assign s_axi_rvalid_o = s.rvalid;
    assign link.cmd_valid = s.cmd_valid;
    assign link.cmd_code = s.cmd_code;
    assign link.cmd_data = s.cmd_data;

endmodule : spr_ctrl

// ---- spr_link_properties.sv ----
// concurrent checks on the command link between controller and register set
`timescale 1ns/1ps
module spr_link_properties (
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    input wire logic cmd_valid_i,
    input wire logic [15:0] cmd_code_i,
    input wire logic rsp_valid_i,
    input wire logic [31:0] rsp_data_i
);
    // ****************************************
    // link timing and answer contents
    // ****************************************
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_b_i);

    // each command gets one answer, one cycle later, and no answer comes uncaused
    chk_rsp_one_cycle: assert property (cmd_valid_i |=> rsp_valid_i)
        else $error("command not answered in one cycle");
    chk_rsp_no_cause: assert property (!cmd_valid_i |=> !rsp_valid_i)
        else $error("answer without a command");
    // controller pulses a command and keeps its code afterwards
    chk_cmd_pulse: assert property (cmd_valid_i |=> !cmd_valid_i [*2])
        else $error("command strobe longer than one cycle");
    chk_cmd_hold: assert property (cmd_valid_i |=> $stable(cmd_code_i))
        else $error("command code changed after strobe");
    // parameter writes, cancel and clear return zero data
    chk_write_zero: assert property (cmd_valid_i
        && (cmd_code_i[15:4] == 12'h009 || cmd_code_i[15:4] == 12'h00B
        || cmd_code_i == 16'h0027 || cmd_code_i == 16'h002D)
        |=> rsp_data_i == 32'h0000_0000)
        else $error("write command returned data");
    // speed reads stay within 17 bits and the clamp value
    chk_speed_clamp: assert property (cmd_valid_i && (cmd_code_i == 16'h00C1
        || cmd_code_i == 16'h00C2 || cmd_code_i == 16'h00D1 || cmd_code_i == 16'h00D2)
        |=> rsp_data_i <= 32'h0001_86A0)
        else $error("speed read above clamp value");
    // rate reads have zero upper half
    chk_rate_width: assert property (cmd_valid_i && (cmd_code_i == 16'h00C3
        || cmd_code_i == 16'h00C4 || cmd_code_i == 16'h00D3 || cmd_code_i == 16'h00D4)
        |=> rsp_data_i[31:16] == 16'h0000)
        else $error("rate read has upper bits set");
    chk_status_width: assert property (cmd_valid_i && cmd_code_i == 16'h0063
        |=> rsp_data_i[31:6] == 26'h0)
        else $error("status read has upper bits set");
endmodule : spr_link_properties

// ---- speed_param_registers_test.sv ----
// self-checking bench: controller and register set joined by the command link
`timescale 1ns/1ps
module speed_param_registers_test;
    // ****************************************
    // stimulus and observed signals
    // ****************************************
    logic clk = 1'h0;
    logic rst_b = 1'h0;
    logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hF;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic running = 1'h0, done = 1'h0, shift = 1'h0, seen_start;
    logic [31:0] wdata = 32'h0, rdata, rd, cmp_val, exp;
    logic awready, wready, bvalid, arready, rvalid, auto_start, cmp_fixed;
    logic [1:0] bresp, rresp, qstat, cstat, rs;
    logic [16:0] init_spd, run_spd;
    logic [15:0] acc, dec;
    int fails = 0;
    int cmp_count = 0;

    always #2.5 clk = ~clk;

    spr_link_if u_spr_link_if ();
    spr_ctrl u_spr_ctrl (.ref_clk_i(clk), .rst_b_i(rst_b), .link(u_spr_link_if),
        .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
        .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
        .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
        .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
        .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
        .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready));
    spr_regs u_spr_regs (.ref_clk_i(clk), .rst_b_i(rst_b), .link(u_spr_link_if),
        .move_running_i(running), .move_done_i(done), .cmp_shift_i(shift),
        .initial_speed_o(init_spd), .running_speed_o(run_spd), .accel_rate_o(acc),
        .decel_rate_o(dec), .queue_status_o(qstat), .auto_start_o(auto_start),
        .comparator_three_value_o(cmp_val), .comparator_queue_status_o(cstat),
        .comparator_fixed_o(cmp_fixed));
    spr_link_properties u_spr_link_properties (.ref_clk_i(clk), .rst_b_i(rst_b),
        .cmd_valid_i(u_spr_link_if.cmd_valid), .cmd_code_i(u_spr_link_if.cmd_code),
        .rsp_valid_i(u_spr_link_if.rsp_valid), .rsp_data_i(u_spr_link_if.rsp_data));

    // ****************************************
    // tasks
    // ****************************************
    task conclude;
        if (fails == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : conclude

    task check(input logic [31:0] seen, input logic [31:0] expv);
        cmp_count++;
        if (seen !== expv)
        begin
            fails++;
            $display("Error at %0t: seen %h expected %h", $time, seen, expv);
        end
    endtask : check

    // a used-up wait bound counts as a mismatch and ends the run
    task guard(input int n);
        if (n >= 60)
        begin
            fails++;
            conclude();
        end
    endtask : guard

    task axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge clk);
        awaddr <= a;
        awvalid <= 1'h1;
        wdata <= d;
        wvalid <= 1'h1;
        bready <= 1'h1;
        do
        begin
            @(posedge clk);
            n++;
            if (awready) awvalid <= 1'h0;
            if (wready) wvalid <= 1'h0;
        end while (bvalid !== 1'h1 && n < 60);
        r = bresp;
        bready <= 1'h0;
        guard(n);
    endtask : axi_wr

    task axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do
        begin
            @(posedge clk);
            n++;
            if (arready) arvalid <= 1'h0;
        end while (rvalid !== 1'h1 && n < 60);
        d = rdata;
        r = rresp;
        rready <= 1'h0;
        guard(n);
    endtask : axi_rd

    // issue one link command, wait for done, then fetch its answer
    task cmd(input logic [15:0] code, input logic [31:0] d);
        int n;
        n = 0;
        axi_wr(4'h4, d, rs);
        axi_wr(4'h0, {16'h0000, code}, rs);
        do
        begin
            axi_rd(4'hC, rd, rs);
            n++;
        end while (rd[1:0] !== 2'h2 && n < 60);
        guard(n);
        axi_rd(4'h8, rd, rs);
    endtask : cmd

    // pulse move completion and watch for the automatic restart
    task finish_move;
        @(posedge clk);
        done <= 1'h1;
        @(posedge clk);
        done <= 1'h0;
        seen_start = 1'h0;
        repeat (3)
        begin
            @(posedge clk);
            seen_start = seen_start | auto_start;
        end
    endtask : finish_move

    // ****************************************
    // main sequence
    // ****************************************
    initial
    begin
        repeat (5) @(posedge clk);
        rst_b <= 1'h1;
        check({15'h0, init_spd}, 32'h0);
        axi_rd(4'h1, rd, rs);
        check({30'h0, rs}, 32'h2);
        axi_wr(4'h3, 32'h0, rs);
        check({30'h0, rs}, 32'h2);
        cmd(16'h0091, 32'h0001_86A1);
        check({15'h0, init_spd}, 32'h0001_86A0);
        cmd(16'h0091, 32'h0001_869F);
        check({15'h0, init_spd}, 32'h0001_869F);
        for (int i = 1; i <= 4; i++)
        begin
            exp = (i < 3) ? 32'h0001_86A0 : 32'h0000_FFFF;
            cmd(16'h0090 + 16'(i), 32'hFFFF_FFFF);
            cmd(16'h00D0 + 16'(i), 32'h0);
            check(rd, exp);
            cmd(16'h00B0 + 16'(i), 32'h0000_1230 + i);
            cmd(16'h00C0 + 16'(i), 32'h0);
            check(rd, 32'h0000_1230 + i);
            cmd(16'h00D0 + 16'(i), 32'h0);
            check(rd, 32'h0000_1230 + i);
        end
        check({15'h0, run_spd}, 32'h1232);
        check({16'h0, acc}, 32'h1233);
        cmd(16'h0094, 32'h0);
        check({16'h0, dec}, 32'h1233);
        cmd(16'h0094, 32'h0055);
        check({16'h0, dec}, 32'h0055);
        cmd(16'h0050, 32'h0);
        check({30'h0, qstat}, 32'h1);
        @(posedge clk);
        running <= 1'h1;
        cmd(16'h00B1, 32'h0777);
        check({15'h0, init_spd}, 32'h1231);
        cmd(16'h0051, 32'h0);
        check({30'h0, qstat}, 32'h2);
        cmd(16'h00B1, 32'h0888);
        cmd(16'h00C1, 32'h0);
        check(rd, 32'h0777);
        cmd(16'h0091, 32'h0500);
        check({15'h0, init_spd}, 32'h0500);
        finish_move();
        check({31'h0, seen_start}, 32'h1);
        check({15'h0, init_spd}, 32'h0777);
        check({30'h0, qstat}, 32'h1);
        finish_move();
        check({30'h0, qstat}, 32'h0);
        running <= 1'h0;
        cmd(16'h0060, 32'hAAAA);
        cmd(16'h0061, 32'hBBBB);
        @(posedge clk);
        shift <= 1'h1;
        @(posedge clk);
        shift <= 1'h0;
        cmd(16'h0061, 32'hCCCC);
        check({30'h0, cstat}, 32'h2);
        cmd(16'h0027, 32'h0);
        check({30'h0, cstat}, 32'h0);
        check({31'h0, cmp_fixed}, 32'h1);
        check(cmp_val, 32'hBBBB);
        cmd(16'h0063, 32'h0);
        check(rd, 32'h0000_0030);
        cmd(16'h002D, 32'h0);
        check({30'h0, cstat}, 32'h0);
        check({31'h0, cmp_fixed}, 32'h0);
        conclude();
    end
endmodule : speed_param_registers_test
